// file: src/phyreg_top.sv
// paged phy register bank: identification page, vendor page with the
// null packet hold flag and link rate, request clearing, power class
// assumes the link drives the register port on this clock and that
// the receiver reports each packet end with its data bit count
`include "phyreg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - page select value 1 in base register 7 maps the identification page.
// R2 - page select value 7 in base register 7 maps the vendor page.
// R3 - paged address 1000b on the id page reads a fixed compliance of 01h.
// R4 - addresses 1010b to 1100b read the 24-bit maker id, msb first.
// R5 - addresses 1101b to 1111b read the 24-bit part code, msb first.
// R6 - with the hold flag set only packets over 8 bits clear requests.
// R7 - with the hold flag clear any non-acknowledge packet clears requests.
// R8 - the hold flag is read-write bit 0 of vendor address 1000b, reset 0.
// R9 - the link writes its top speed into bits 6 to 7 and the phy keeps it.
// R10 - rate codes 00, 01, 10 are S100, S200, S400; 11 is not valid.
// R11 - the strap pins give the default self-id power field.
// R12 - straps load after reset; a later base register 4 write replaces them.
// R13 - codes 000 to 011 mean no power or self powered 15, 30, 45 W.
// R14 - codes 100, 110, 111: bus powered, 0, 3, 7 W more needed; 101 reserved.
module phyreg_top
#(
   parameter logic [23:0] MAKER_OUI = 24'h12_3456, // arbitrary value
   parameter logic [23:0] PART_CODE = 24'h65_4321 // arbitrary value
)
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire phyreg_pkg::phyreg_bus_t bus_in,
   output logic [7:0] rd_data_out,
   input wire phyreg_pkg::phyreg_rx_t rx_in,
   input wire phyreg_pkg::phyreg_req_t req_set_in,
   output var phyreg_pkg::phyreg_req_t pend_out,
   output var phyreg_pkg::phyreg_rate_t link_rate_out,
   output logic link_rate_valid_out,
   output logic null_hold_out,
   output logic [2:0] page_sel_out,
   output logic [3:0] port_sel_out,
   input wire logic [2:0] power_class_straps_in,
   output logic [2:0] self_id_pwr_out,
   output var phyreg_pkg::phyreg_pwr_info_t pwr_info_out
);
   import phyreg_pkg::*;

   logic rd;
   logic wr;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [2:0] page_q;
   logic [3:0] port_q;
   logic hold_q;
   phyreg_rate_t rate_q;
   logic rate_valid_q;
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;
   logic [1:0] pend_q;
   logic [1:0] pend_set;
   logic req_clear;
   logic pwr_wr;
   logic vendor_ctrl_wr;

   // unpack the register port
   assign rd = bus_in.rd;
   assign wr = bus_in.wr;
   assign addr = bus_in.addr;
   assign wdata = bus_in.wdata;

   // identification page contents by paged address
   function automatic logic [7:0] id_byte(input logic [3:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a == `PHYREG_ADDR_COMPLIANCE)
         r = `PHYREG_COMPLIANCE;
      else if (a == `PHYREG_ADDR_OUI_HI)
         r = MAKER_OUI[23:16];
      else if (a == `PHYREG_ADDR_OUI_MID)
         r = MAKER_OUI[15:8];
      else if (a == `PHYREG_ADDR_OUI_LO)
         r = MAKER_OUI[7:0];
      else if (a == `PHYREG_ADDR_PART_HI)
         r = PART_CODE[23:16];
      else if (a == `PHYREG_ADDR_PART_MID)
         r = PART_CODE[15:8];
      else if (a == `PHYREG_ADDR_PART_LO)
         r = PART_CODE[7:0];
      return r;
   endfunction

   // rate code is usable unless it is the invalid code
   function automatic logic rate_ok(input logic [1:0] r);
      return r != PHYREG_RATE_BAD;
   endfunction

   // whether a received packet clears pending requests
   function automatic logic clears_req(input logic hold,
                                       input logic [15:0] bits);
      logic r;
      if (hold)
         r = bits > `PHYREG_ACK_BITS;
      else
         r = bits != `PHYREG_ACK_BITS;
      return r;
   endfunction

   // write decode for registers held outside the page logic
   assign pwr_wr = wr && addr == `PHYREG_ADDR_PWR;
   assign vendor_ctrl_wr = wr && addr == `PHYREG_ADDR_CTRL &&
                           page_q == `PHYREG_PAGE_VENDOR;

   // base register 7: page and port selectors
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         page_q <= `PHYREG_PAGE_RST;
         port_q <= `PHYREG_PORT_RST;
      end
      else if (wr && addr == `PHYREG_ADDR_PAGE)
      begin
         page_q <= wdata[`PHYREG_PAGE_MSB:`PHYREG_PAGE_LSB]; // R1 R2
         port_q <= wdata[`PHYREG_PORT_MSB:`PHYREG_PORT_LSB];
      end
   end

   // vendor page control byte: hold flag and link rate
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         hold_q <= `PHYREG_HOLD_RST; // R8
         rate_q <= phyreg_rate_t'(`PHYREG_RATE_RST);
      end
      else if (vendor_ctrl_wr)
      begin
         hold_q <= wdata[`PHYREG_HOLD_BIT]; // R8
         rate_q <= phyreg_rate_t'(wdata[`PHYREG_RATE_MSB:
                                        `PHYREG_RATE_LSB]); // R9
      end
   end

   // link rate validity for speed decisions
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         rate_valid_q <= 1'b1;
      else
         rate_valid_q <= rate_ok(rate_q); // R10
   end

   // read data selection by page and address
   always_comb
   begin
      rd_data_d = 8'h00;
      if (!rd)
         rd_data_d = 8'h00;
      else if (addr == `PHYREG_ADDR_PAGE)
         rd_data_d = {page_q, 1'b0, port_q};
      else if (addr == `PHYREG_ADDR_PWR)
         rd_data_d = {5'h00, self_id_pwr_out};
      else if (addr[3] && page_q == `PHYREG_PAGE_ID)
         rd_data_d = id_byte(addr); // R1 R3 R4 R5
      else if (addr == `PHYREG_ADDR_CTRL &&
               page_q == `PHYREG_PAGE_VENDOR)
         rd_data_d = {hold_q, 5'h00, rate_q}; // R2 R8 R9
   end

   // read data stands for the cycle after the strobe only
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         rd_data_q <= 8'h00;
      else
         rd_data_q <= rd_data_d;
   end

   // clear term from the received packet length
   assign req_clear = rx_in.done && clears_req(hold_q, rx_in.bits); // R6 R7
   assign pend_set = {req_set_in.fair, req_set_in.pri};

   // pending fair and priority requests, a new request beats a clear
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_pend
         always_ff @(posedge sys_clk_in or posedge reset_in)
         begin
            if (reset_in)
               pend_q[i] <= 1'b0;
            else if (pend_set[i])
               pend_q[i] <= 1'b1;
            else if (req_clear)
               pend_q[i] <= 1'b0; // R6 R7
         end
      end
   endgenerate

   // power class holder
   phyreg_pwr_class u_pwr
   (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .power_class_straps_in(power_class_straps_in),
      .wr_in(pwr_wr),
      .wdata_in(wdata[`PHYREG_PWR_MSB:`PHYREG_PWR_LSB]),
      .pwr_class_out(self_id_pwr_out),
      .info_out(pwr_info_out)
   );

   // outputs straight from flops
   assign rd_data_out = rd_data_q;
   assign pend_out = phyreg_req_t'(pend_q); // fair is bit 1
   assign link_rate_out = rate_q;
   assign link_rate_valid_out = rate_valid_q;
   assign null_hold_out = hold_q;
   assign page_sel_out = page_q;
   assign port_sel_out = port_q;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   sequence s_sel_page(logic [7:0] pg);
      wr && addr == `PHYREG_ADDR_PAGE && wdata == pg;
   endsequence

   sequence s_rd(logic [3:0] a);
      rd && !wr && addr == a;
   endsequence

   property p_id_compliance;
      s_sel_page(8'h20) ##1 s_rd(4'h8) |=> rd_data_out == 8'h01;
   endproperty
   a_id_compliance: assert property (p_id_compliance) // R1 R3
      else $error("compliance byte wrong");

   property p_oui_high;
      page_q == 3'h1 && rd && addr == 4'ha
         |=> rd_data_out == MAKER_OUI[23:16];
   endproperty
   a_oui_high: assert property (p_oui_high) // R4
      else $error("maker id high byte wrong");

   property p_part_low;
      page_q == 3'h1 && rd && addr == 4'hf
         |=> rd_data_out == PART_CODE[7:0];
   endproperty
   a_part_low: assert property (p_part_low) // R5
      else $error("part code low byte wrong");

   property p_vendor_readback;
      s_sel_page(8'he0) ##1 (wr && addr == 4'h8) ##1 s_rd(4'h8)
         |=> rd_data_out == {$past(wdata, 2) & 8'h83};
   endproperty
   a_vendor_readback: assert property (p_vendor_readback) // R2 R8 R9
      else $error("vendor control readback wrong");

   property p_hold_keeps;
      hold_q && rx_in.done && rx_in.bits <= 16'h0008 && pend_set == 2'b00
         |=> pend_q == $past(pend_q);
   endproperty
   a_hold_keeps: assert property (p_hold_keeps) // R6
      else $error("short packet cleared a request");

   property p_free_clears;
      !hold_q && rx_in.done && rx_in.bits != 16'h0008 &&
         pend_set == 2'b00 |=> pend_q == 2'b00;
   endproperty
   a_free_clears: assert property (p_free_clears) // R7
      else $error("non-ack packet left a request");

   property p_set_wins;
      pend_set[1] |=> pend_out.fair;
   endproperty
   a_set_wins: assert property (p_set_wins) // R6 R7
      else $error("fair request lost");

   property p_rate_valid;
      ##1 link_rate_valid_out == ($past(rate_q) != 2'b11);
   endproperty
   a_rate_valid: assert property (p_rate_valid) // R10
      else $error("rate valid wrong");

   property p_page_map;
      wr && addr == `PHYREG_ADDR_PAGE
         |=> {page_sel_out, 5'h00} == ($past(wdata) & 8'he0);
   endproperty
   a_page_map: assert property (p_page_map) // R1 R2
      else $error("page selector not taken");

   property p_id_readonly;
      wr && addr[3] && page_q == `PHYREG_PAGE_ID
         |=> $stable(hold_q) && $stable(rate_q);
   endproperty
   a_id_readonly: assert property (p_id_readonly) // R3 R4 R5
      else $error("write on id page changed state");

   property p_rate_kept;
      !vendor_ctrl_wr |=> $stable(rate_q);
   endproperty
   a_rate_kept: assert property (p_rate_kept) // R9
      else $error("link rate changed without a write");

   property p_rd_once;
      !rd |=> rd_data_out == 8'h00;
   endproperty
   a_rd_once: assert property (p_rd_once)
      else $error("read data outside its cycle");

endmodule

`default_nettype wire

// file: src/phyreg_defines.svh
// register offsets, field positions, reset values and timing counts
// for the paged phy register bank; included by bare name
`ifndef PHYREG_DEFINES_SVH
`define PHYREG_DEFINES_SVH

// base register addresses
`define PHYREG_ADDR_PWR 4'h4
`define PHYREG_ADDR_PAGE 4'h7

// paged window addresses
`define PHYREG_ADDR_COMPLIANCE 4'h8
`define PHYREG_ADDR_OUI_HI 4'ha
`define PHYREG_ADDR_OUI_MID 4'hb
`define PHYREG_ADDR_OUI_LO 4'hc
`define PHYREG_ADDR_PART_HI 4'hd
`define PHYREG_ADDR_PART_MID 4'he
`define PHYREG_ADDR_PART_LO 4'hf
`define PHYREG_ADDR_CTRL 4'h8

// page selector values
`define PHYREG_PAGE_ID 3'h1
`define PHYREG_PAGE_VENDOR 3'h7

// field positions, bit 0 of the tables is the byte msb
`define PHYREG_PAGE_MSB 7
`define PHYREG_PAGE_LSB 5
`define PHYREG_PORT_MSB 3
`define PHYREG_PORT_LSB 0
`define PHYREG_PWR_MSB 2
`define PHYREG_PWR_LSB 0
`define PHYREG_HOLD_BIT 7
`define PHYREG_RATE_MSB 1
`define PHYREG_RATE_LSB 0

// fixed and reset values
`define PHYREG_COMPLIANCE 8'h01
`define PHYREG_PAGE_RST 3'h0
`define PHYREG_PORT_RST 4'h0
`define PHYREG_HOLD_RST 1'b0
`define PHYREG_RATE_RST 2'h0
`define PHYREG_PWR_RST 3'h0

// packet length of an acknowledge, in data bits
`define PHYREG_ACK_BITS 16'h0008

// cycles after reset release before straps are taken
`define PHYREG_STRAP_SETTLE 2'h2

// power budget figures in watts
`define PHYREG_W15 6'h0f
`define PHYREG_W30 6'h1e
`define PHYREG_W45 6'h2d
`define PHYREG_X3 4'h3
`define PHYREG_X7 4'h7

`endif

// file: src/phyreg_pkg.sv
// types shared by the paged phy register bank
// assumes phyreg_defines.svh holds the numeric constants
package phyreg_pkg;

   // attached link rate codes
   typedef enum logic [1:0]
   {
      PHYREG_S100 = 2'b00,
      PHYREG_S200 = 2'b01,
      PHYREG_S400 = 2'b10,
      PHYREG_RATE_BAD = 2'b11
   } phyreg_rate_t;

   // register port request from the link
   typedef struct packed
   {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } phyreg_bus_t;

   // end of a received packet and its data bit count
   typedef struct packed
   {
      logic done;
      logic [15:0] bits;
   } phyreg_rx_t;

   // fair and priority arbitration requests
   typedef struct packed
   {
      logic fair;
      logic pri;
   } phyreg_req_t;

   // decoded meaning of the power class
   typedef struct packed
   {
      logic no_power;
      logic self_powered;
      logic bus_powered;
      logic reserved;
      logic [5:0] supply_w;
      logic [3:0] extra_w;
   } phyreg_pwr_info_t;

endpackage

// file: src/phyreg_pwr_class.sv
// power class holder: strap sampling after reset, link override, decode
// assumes straps are static pins from outside the clock domain
`include "phyreg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module phyreg_pwr_class
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [2:0] power_class_straps_in,
   input wire logic wr_in,
   input wire logic [2:0] wdata_in,
   output logic [2:0] pwr_class_out,
   output var phyreg_pkg::phyreg_pwr_info_t info_out
);
   import phyreg_pkg::*;

   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;
   logic [1:0] settle_q;
   logic loaded_q;
   logic [2:0] pwr_q;
   phyreg_pwr_info_t info_q;

   // meaning of each power class code
   function automatic phyreg_pwr_info_t decode(input logic [2:0] code);
      phyreg_pwr_info_t r;
      r = '0;
      if (code == 3'b000)
         r.no_power = 1'b1;
      else if (code == 3'b001)
      begin
         r.self_powered = 1'b1;
         r.supply_w = `PHYREG_W15;
      end
      else if (code == 3'b010)
      begin
         r.self_powered = 1'b1;
         r.supply_w = `PHYREG_W30;
      end
      else if (code == 3'b011)
      begin
         r.self_powered = 1'b1;
         r.supply_w = `PHYREG_W45;
      end
      else if (code == 3'b100)
         r.bus_powered = 1'b1;
      else if (code == 3'b101)
         r.reserved = 1'b1;
      else if (code == 3'b110)
      begin
         r.bus_powered = 1'b1;
         r.extra_w = `PHYREG_X3;
      end
      else
      begin
         r.bus_powered = 1'b1;
         r.extra_w = `PHYREG_X7;
      end
      return r;
   endfunction

   // two stage synchroniser on the strap pins
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
      end
      else
      begin
         strap_s1_q <= power_class_straps_in;
         strap_s2_q <= strap_s1_q;
      end
   end

   // settle count before the straps are trusted
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         settle_q <= 2'h0;
      else if (settle_q != `PHYREG_STRAP_SETTLE)
         settle_q <= settle_q + 2'h1;
   end

   // strap default once after reset, any link write replaces it
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         pwr_q <= `PHYREG_PWR_RST;
         loaded_q <= 1'b0;
      end
      else if (wr_in)
      begin
         pwr_q <= wdata_in; // R12
         loaded_q <= 1'b1;
      end
      else if (!loaded_q && settle_q == `PHYREG_STRAP_SETTLE)
      begin
         pwr_q <= strap_s2_q; // R11 R12
         loaded_q <= 1'b1;
      end
   end

   // registered decode of the current class
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         info_q <= '0;
      else
         info_q <= decode(pwr_q); // R13 R14
   end

   assign pwr_class_out = pwr_q;
   assign info_out = info_q;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   property p_strap_load;
      !loaded_q && settle_q == `PHYREG_STRAP_SETTLE && !wr_in
         |=> pwr_class_out == $past(strap_s2_q);
   endproperty
   a_strap_load: assert property (p_strap_load) // R11
      else $error("strap class not loaded");

   property p_link_override;
      wr_in ##1 !wr_in [*2] |-> pwr_class_out == $past(wdata_in, 2);
   endproperty
   a_link_override: assert property (p_link_override) // R12
      else $error("link power class not kept");

   property p_self_powered;
      pwr_class_out == 3'b011 |=> info_out.self_powered &&
         info_out.supply_w == 6'h2d;
   endproperty
   a_self_powered: assert property (p_self_powered) // R13
      else $error("class 011 decode wrong");

   property p_bus_extra;
      pwr_class_out == 3'b111 |=> info_out.bus_powered &&
         info_out.extra_w == 4'h7;
   endproperty
   a_bus_extra: assert property (p_bus_extra) // R14
      else $error("class 111 decode wrong");

endmodule

`default_nettype wire

// file: verif/phyreg_link_model.sv
// link layer controller model that drives the phy register port
// assumes the register bank samples strobes on the rising clock edge
`include "phyreg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module phyreg_link_model
(
   input wire logic sys_clk_in,
   input wire logic [7:0] rd_data_in,
   output var phyreg_pkg::phyreg_bus_t bus_out
);
   import phyreg_pkg::*;

   // port idle until the first request
   initial bus_out = '0;

   // one-cycle write; address and data are scrambled once released
   task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
   endtask

   // one-cycle read; data taken in the cycle after the strobe
   task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'h5a};
      #1 data = rd_data_in;
   endtask

   // page selector in base register 7, port select left at 0
   task automatic select_page(input logic [2:0] page);
      write_reg(`PHYREG_ADDR_PAGE, {page, 5'h00});
   endtask

   // hold flag and own top speed on the vendor page
   task automatic write_ctrl(input logic hold, input logic [1:0] rate);
      select_page(`PHYREG_PAGE_VENDOR);
      write_reg(`PHYREG_ADDR_CTRL, {hold, 5'h00, rate});
   endtask

   // page write, optional write, then a read, with no idle cycle between
   task automatic select_read(input logic [2:0] page, input logic wr_first,
      input logic [7:0] wr_data, input logic [3:0] rd_addr,
      output logic [7:0] data);
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b0, wr: 1'b1, addr: `PHYREG_ADDR_PAGE,
         wdata: {page, 5'h00}};
      if (wr_first)
      begin
         @(posedge sys_clk_in);
         bus_out <= '{rd: 1'b0, wr: 1'b1, addr: rd_addr, wdata: wr_data};
      end
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b1, wr: 1'b0, addr: rd_addr, wdata: 8'h00};
      @(posedge sys_clk_in);
      bus_out <= '{rd: 1'b0, wr: 1'b0, addr: ~rd_addr, wdata: 8'h5a};
      #1 data = rd_data_in;
   endtask
endmodule

`default_nettype wire

// file: verif/phyreg_top_tb.sv
// self-checking bench for the paged phy register bank
// assumes the link model file and the package are compiled first
`include "phyreg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module phyreg_top_tb;
   import phyreg_pkg::*;

   localparam logic [23:0] OUI = 24'h9a_bc12; // arbitrary value
   localparam logic [23:0] PART = 24'h3c_5e71; // arbitrary value

   logic sys_clk_in;
   logic reset_in;
   phyreg_bus_t bus;
   logic [7:0] rd_data;
   phyreg_rx_t rx;
   phyreg_req_t req_set;
   phyreg_req_t pend;
   phyreg_rate_t link_rate;
   logic rate_valid;
   logic null_hold;
   logic [2:0] page_sel;
   logic [3:0] port_sel;
   logic [2:0] straps;
   logic [2:0] pwr;
   phyreg_pwr_info_t pwr_info;
   int fail_count;
   int checks;

   // bank under test with its own identity values
   phyreg_top #(.MAKER_OUI(OUI), .PART_CODE(PART)) dut
   (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .bus_in(bus),
      .rd_data_out(rd_data),
      .rx_in(rx),
      .req_set_in(req_set),
      .pend_out(pend),
      .link_rate_out(link_rate),
      .link_rate_valid_out(rate_valid),
      .null_hold_out(null_hold),
      .page_sel_out(page_sel),
      .port_sel_out(port_sel),
      .power_class_straps_in(straps),
      .self_id_pwr_out(pwr),
      .pwr_info_out(pwr_info)
   );

   // link side of the register port
   phyreg_link_model link
   (
      .sys_clk_in(sys_clk_in),
      .rd_data_in(rd_data),
      .bus_out(bus)
   );

   // 100 MHz clock
   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // compare one value and count it
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
      input string msg);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // expected meaning of a power class code
   function automatic phyreg_pwr_info_t exp_info(input logic [2:0] code);
      phyreg_pwr_info_t i;
      i = '0;
      case (code)
         3'h0: i.no_power = 1'b1;
         3'h1, 3'h2, 3'h3:
         begin
            i.self_powered = 1'b1;
            i.supply_w = 6'(code * 15);
         end
         3'h5: i.reserved = 1'b1;
         default:
         begin
            i.bus_powered = 1'b1;
            i.extra_w = (code == 3'h6) ? 4'h3 : (code == 3'h7) ? 4'h7 : 4'h0;
         end
      endcase
      return i;
   endfunction

   // values after reset, straps loaded
   task automatic test_reset;
      logic [7:0] d;
      check(16'(page_sel), 16'h0000, "page after reset");
      check(16'(port_sel), 16'h0000, "port after reset");
      check(16'(null_hold), 16'h0000, "hold after reset");
      check(16'(link_rate), 16'h0000, "rate after reset");
      check(16'(rate_valid), 16'h0001, "rate valid after reset");
      check(16'(pend), 16'h0000, "pending after reset");
      check(16'(pwr), 16'h0006, "strap power class");
      check(16'(pwr_info), 16'(exp_info(3'h6)), "strap meaning");
      link.select_page(`PHYREG_PAGE_VENDOR);
      link.read_reg(`PHYREG_ADDR_CTRL, d);
      check(16'(d), 16'h0000, "control after reset");
   endtask

   // identification page contents, writes refused
   task automatic test_id_page;
      logic [7:0] d;
      logic [7:0] exp [8:15];
      exp = '{8'h01, 8'h00, OUI[23:16], OUI[15:8], OUI[7:0],
         PART[23:16], PART[15:8], PART[7:0]};
      link.select_read(`PHYREG_PAGE_ID, 1'b0, 8'h00,
         `PHYREG_ADDR_COMPLIANCE, d);
      check(16'(d), 16'h0001, "compliance after select");
      check(16'(page_sel), 16'h0001, "id page select");
      link.write_reg(`PHYREG_ADDR_COMPLIANCE, 8'hff);
      for (int a = 8; a < 16; a++)
      begin
         link.read_reg(a[3:0], d);
         check(16'(d), 16'(exp[a]), "id page byte");
      end
      check(16'(null_hold), 16'h0000, "id write leaks to hold");
   endtask

   // vendor control: readback, every rate code, unmapped places
   task automatic test_vendor;
      logic [7:0] d;
      link.select_read(`PHYREG_PAGE_VENDOR, 1'b1, 8'h81,
         `PHYREG_ADDR_CTRL, d);
      check(16'(page_sel), 16'h0007, "vendor page select");
      check(16'(d), 16'h0081, "control readback");
      check(16'(null_hold), 16'h0001, "hold flag set");
      for (int r = 0; r < 4; r++)
      begin
         link.write_reg(`PHYREG_ADDR_CTRL, {6'h00, r[1:0]});
         @(posedge sys_clk_in);
         #1;
         check(16'(link_rate), 16'(r[1:0]), "link rate");
         check(16'(rate_valid), 16'(r != 3), "rate valid");
      end
      link.read_reg(4'ha, d);
      check(16'(d), 16'h0000, "unmapped vendor address");
      link.write_reg(`PHYREG_ADDR_PAGE, 8'h05);
      link.read_reg(`PHYREG_ADDR_PAGE, d);
      check(16'(d), 16'h0005, "base register 7 readback");
      check(16'(port_sel), 16'h0005, "port select");
      link.read_reg(`PHYREG_ADDR_CTRL, d);
      check(16'(d), 16'h0000, "window on page zero");
   endtask

   // raise both requests, end one packet, judge what stays pending
   task automatic arb_case(input logic hold, input logic [15:0] bits,
      input logic [1:0] exp);
      link.write_ctrl(hold, 2'b00);
      @(posedge sys_clk_in);
      req_set <= '{fair: 1'b1, pri: 1'b1};
      @(posedge sys_clk_in);
      req_set <= '0;
      rx <= '{done: 1'b1, bits: bits};
      #1;
      check(16'(pend), 16'h0003, "requests pending");
      @(posedge sys_clk_in);
      rx <= '{done: 1'b0, bits: ~bits};
      #1;
      check(16'(pend), 16'(exp), "pending after packet");
   endtask

   // null, malformed and acknowledge packets under both flags, a long packet with the hold flag set
   task automatic test_arb;
      arb_case(1'b0, 16'h0000, 2'b00);
      arb_case(1'b0, 16'h0004, 2'b00);
      arb_case(1'b0, 16'h0008, 2'b11);
      arb_case(1'b1, 16'h0008, 2'b11);
      arb_case(1'b1, 16'h0000, 2'b11);
      arb_case(1'b1, 16'h0004, 2'b11);
      arb_case(1'b1, 16'h0009, 2'b00);
   endtask

   // every power class written over the strap value
   task automatic test_power;
      logic [7:0] d;
      for (int c = 0; c < 8; c++)
      begin
         link.write_reg(`PHYREG_ADDR_PWR, {5'h00, c[2:0]});
         #1;
         check(16'(pwr), 16'(c[2:0]), "power class write");
         @(posedge sys_clk_in);
         #1;
         check(16'(pwr_info), 16'(exp_info(c[2:0])), "meaning");
         link.read_reg(`PHYREG_ADDR_PWR, d);
         check(16'(d), 16'(c[2:0]), "power class readback");
      end
   endtask

   // reset in mid-run: straps reload over the written class, flag clears
   task automatic test_mid_reset;
      @(posedge sys_clk_in);
      straps <= 3'h2;
      reset_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      #1;
      check(16'(null_hold), 16'h0000, "hold after mid reset");
      check(16'(page_sel), 16'h0000, "page after mid reset");
      check(16'(pwr), 16'h0002, "straps reloaded");
      check(16'(pwr_info), 16'(exp_info(3'h2)), "reload meaning");
   endtask

   // reset for 20 cycles, then every scenario in turn
   initial
   begin
      fail_count = 0;
      checks = 0;
      reset_in = 1'b1;
      rx = '0;
      req_set = '0;
      straps = 3'h6;
      repeat (20) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      #1;
      test_reset;
      test_id_page;
      test_vendor;
      test_arb;
      test_power;
      test_mid_reset;
      test_done;
   end

   // the run needs well under 1000 cycles; a hang is cut at 20000
   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      fail_count++;
      test_done;
   end
endmodule

`default_nettype wire
